//--- core/mbac_defines.vh
// Constants for the mode based access control block
`ifndef MBAC_DEFINES_VH
`define MBAC_DEFINES_VH
`define MBAC_NSEG 64
`define MBAC_NWORD 7'h7F
`define MBAC_VA_W 16
`define MBAC_PA_W 24
// Memory operation codes
`define MBAC_OP_RD 2'h0
`define MBAC_OP_WR 2'h1
`define MBAC_OP_EX 2'h2
// Register operand classes
`define MBAC_SFR_GEN 2'h0
`define MBAC_SFR_HW 2'h1
`define MBAC_SFR_SYS 2'h2
`define MBAC_SFR_FW 2'h3
// Privilege modes
`define MBAC_M_BOOT 3'h0
`define MBAC_M_TEST 3'h1
`define MBAC_M_OS 3'h2
`define MBAC_M_SYS 3'h3
`define MBAC_M_USER 3'h4
// Status word high fields
`define MBAC_SWH_SYS 0
`define MBAC_SWH_OS 1
// Entry word 1 fields
`define MBAC_E_R 16
`define MBAC_E_X 18
`define MBAC_E_SFR 19
// APB byte offsets
`define MBAC_A_CTRL 8'h00
`define MBAC_A_SWH 8'h04
`define MBAC_A_PTR 8'h08
`define MBAC_A_FWL 8'h0C
`define MBAC_A_FWH 8'h10
`define MBAC_A_XBL 8'h14
`define MBAC_A_XBH 8'h18
`define MBAC_A_XSL 8'h1C
`define MBAC_A_XSH 8'h20
`define MBAC_A_MODE 8'h24
`define MBAC_A_FLT 8'h28
`define MBAC_A_FADR 8'h2C
// Control bits
`define MBAC_C_LOAD 0
`define MBAC_C_BEXIT 1
// Physical regions and firewall guard bit
`define MBAC_RAM_BASE 24'h000000
`define MBAC_RAM_SIZE 24'h001800
`define MBAC_NVM_MFR_BASE 24'h020000
`define MBAC_NVM_MFR_SIZE 24'h000080
`define MBAC_FW_GUARD 0
`endif

//--- core/mbac_seg_match.v
// One segment entry compared against a virtual address
`include "mbac_defines.vh"
module mbac_seg_match (
    input wire [15:0] first,
    input wire [15:0] last,
    input wire [15:0] offset,
    input wire [2:0] perm,
    input wire [15:0] vaddr,
    input wire [1:0] op,
    output wire hit,
    output wire [23:0] paddr
);
    // Offset counts 256-byte pages so the table stays 16 bits wide
    assign paddr = {8'h00, vaddr} + {offset, 8'h00};
    // No permission at all means the entry is off
    assign hit = (|perm) && (vaddr >= first) && (vaddr <= last) && perm[op];
endmodule // mbac_seg_match

//--- core/mbac_top.v
// Privilege mode, segment table and firewall check for CPU accesses
// Summary of operation
// - Five modes from status word high plus internal boot and test bits.
// - Variant without OS mode offers only system and user modes to code.
// - Without OS mode, vectored OS calls leave the mode alone, like indirect calls.
// - Reads, writes and executes are each checked against the policy.
// - Register reads and writes are each checked against the policy.
// - Each of 64 entries holds rwx, first and last address, relocation offset.
// - Each entry also says whether its code may touch hardware registers in user mode.
// - An entry with no rwx permission is disabled and never matches.
// - Any count of defined entries from zero to 64 works.
// - Table is fetched from physical memory at a software pointer.
// - Firewall and exchange window limit OS mode registers and RAM.
// - Without OS mode, 128 bytes of nonvolatile memory stay reserved.
// - Outside boot and test modes, every virtual address is translated and checked before memory access.
// - Without OS mode, system and user modes reach RAM whatever the firewall.
`include "mbac_defines.vh"
module mbac_top (
    input wire clk_sys,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire variant_no_os,
    input wire test_mode_req,
    input wire vectored_os_call,
    input wire cpu_req,
    input wire [1:0] cpu_op,
    input wire [15:0] cpu_vaddr,
    input wire [7:0] cpu_wdata,
    input wire sfr_req,
    input wire sfr_write,
    input wire [1:0] sfr_class,
    input wire [3:0] sfr_unit,
    input wire [7:0] sfr_addr,
    output reg acc_done_q,
    output reg acc_fault_q,
    output reg mem_en_q,
    output reg mem_we_q,
    output reg [23:0] mem_addr_q,
    output reg [7:0] mem_wdata_q,
    output reg sfr_en_q,
    output reg sfr_we_q,
    output reg [7:0] sfr_addr_q,
    output reg [7:0] sfr_wdata_q,
    output reg [2:0] mode_q,
    output reg os_switch_q,
    output reg tbl_req_q,
    output reg [23:0] tbl_addr_q,
    input wire [31:0] tbl_rdata,
    input wire tbl_ack
);
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_WAIT = 2'h2;
    function in_win;
        input [23:0] a;
        input [23:0] base;
        input [23:0] size;
        begin
            in_win = (a >= base) && ((a - base) < size);
        end
    endfunction
    reg [7:0] swh_q;
    reg boot_q;
    reg test_q;
    reg [23:0] ptr_q;
    reg [15:0] fw_q;
    reg [15:0] xbase_q;
    reg [15:0] xsize_q;
    reg flt_q;
    reg [1:0] flt_op_q;
    reg flt_sfr_q;
    reg [15:0] flt_addr_q;
    reg code_sfr_q;
    reg [1:0] st_q;
    reg [6:0] wcnt_q;
    reg [255:0] perm_q;
    reg [15:0] seg_first [0:63];
    reg [15:0] seg_last [0:63];
    reg [15:0] seg_off [0:63];
    reg [2:0] mode_d;
    wire [63:0] hit;
    wire [1535:0] hit_pa;
    reg [5:0] sel;
    reg found;
    reg mem_ok;
    reg sfr_ok;
    reg [23:0] pa;
    reg ram_ok;
    wire loading = (st_q != ST_IDLE);
    wire priv = (mode_q == `MBAC_M_BOOT) || (mode_q == `MBAC_M_TEST);
    wire [23:0] xw_base = `MBAC_RAM_BASE + {8'h00, xbase_q};
    wire apb_fin = psel && penable && pready;
    wire apb_wr = apb_fin && pwrite;
    wire clr_flt = apb_wr && (paddr == `MBAC_A_FLT) && pwdata[0];
    wire load_go = apb_wr && (paddr == `MBAC_A_CTRL) && pwdata[`MBAC_C_LOAD];
    genvar g;
    generate
        for (g = 0; g < `MBAC_NSEG; g = g + 1) begin : g_seg
            mbac_seg_match u_match (
                .first(seg_first[g]),
                .last(seg_last[g]),
                .offset(seg_off[g]),
                .perm(perm_q[4*g +: 3]),
                .vaddr(cpu_vaddr),
                .op(cpu_op),
                .hit(hit[g]),
                .paddr(hit_pa[24*g +: 24])
            );
        end
    endgenerate
    // OS bit is ignored in the reduced variant
    always @* begin
        if (boot_q) begin
            mode_d = `MBAC_M_BOOT;
        end else if (test_q) begin
            mode_d = `MBAC_M_TEST;
        end else if (swh_q[`MBAC_SWH_OS] && !variant_no_os) begin
            mode_d = `MBAC_M_OS;
        end else if (swh_q[`MBAC_SWH_SYS]) begin
            mode_d = `MBAC_M_SYS;
        end else begin
            mode_d = `MBAC_M_USER;
        end
    end
    // Lowest index wins; empty table simply never hits
    integer i;
    always @* begin
        sel = 6'h00;
        found = 1'b0;
        for (i = `MBAC_NSEG - 1; i >= 0; i = i - 1) begin
            if (hit[i]) begin
                sel = i[5:0];
                found = 1'b1;
            end
        end
    end
    // Memory check: translation first, then region policy
    always @* begin
        ram_ok = 1'b1;
        if (priv) begin
            pa = {8'h00, cpu_vaddr};
            mem_ok = 1'b1;
        end else begin
            pa = hit_pa[24*sel +: 24];
            // Half-loaded table cannot be trusted
            mem_ok = found && !loading;
            if (variant_no_os) begin
                if (in_win(pa, `MBAC_NVM_MFR_BASE, `MBAC_NVM_MFR_SIZE)) begin
                    mem_ok = 1'b0;
                end
            end else if (in_win(pa, `MBAC_RAM_BASE, `MBAC_RAM_SIZE)) begin
                if (mode_q == `MBAC_M_OS) begin
                    ram_ok = in_win(pa, xw_base, {8'h00, xsize_q});
                end else if (fw_q[`MBAC_FW_GUARD]) begin
                    ram_ok = !in_win(pa, xw_base, {8'h00, xsize_q});
                end
            end
            // Reduced variant: RAM open to system and user whatever the firewall
            mem_ok = mem_ok && ram_ok;
        end
    end
    // Register check per class and mode
    always @* begin
        case (sfr_class)
            `MBAC_SFR_GEN: sfr_ok = 1'b1;
            `MBAC_SFR_HW: begin
                if (priv || mode_q == `MBAC_M_SYS) begin
                    sfr_ok = 1'b1;
                end else if (mode_q == `MBAC_M_OS) begin
                    sfr_ok = fw_q[sfr_unit];
                end else begin
                    sfr_ok = code_sfr_q;
                end
            end
            default: sfr_ok = priv || (mode_q == `MBAC_M_SYS);
        endcase
    end
    // Access outcome, registered; refused requests raise no enable
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc_done_q <= 1'b0;
            acc_fault_q <= 1'b0;
            mem_en_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 24'h000000;
            mem_wdata_q <= 8'h00;
            sfr_en_q <= 1'b0;
            sfr_we_q <= 1'b0;
            sfr_addr_q <= 8'h00;
            sfr_wdata_q <= 8'h00;
            code_sfr_q <= 1'b0;
        end else begin
            acc_done_q <= cpu_req || sfr_req;
            acc_fault_q <= (cpu_req && !mem_ok) || (!cpu_req && sfr_req && !sfr_ok);
            mem_en_q <= cpu_req && mem_ok;
            mem_we_q <= cpu_req && mem_ok && (cpu_op == `MBAC_OP_WR);
            sfr_en_q <= !cpu_req && sfr_req && sfr_ok;
            sfr_we_q <= !cpu_req && sfr_req && sfr_ok && sfr_write;
            if (cpu_req) begin
                mem_addr_q <= pa;
                mem_wdata_q <= cpu_wdata;
            end
            if (sfr_req) begin
                sfr_addr_q <= sfr_addr;
                sfr_wdata_q <= cpu_wdata;
            end
            // Fetch from a segment decides its hardware register rights
            if (cpu_req && mem_ok && cpu_op == `MBAC_OP_EX) begin
                code_sfr_q <= priv ? 1'b0 : perm_q[4*sel + `MBAC_E_SFR - `MBAC_E_R];
            end
        end
    end
    // Mode state and calls
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q <= `MBAC_M_BOOT;
            boot_q <= 1'b1;
            test_q <= 1'b0;
            swh_q <= 8'h00;
            os_switch_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            test_q <= test_mode_req;
            if (apb_wr && paddr == `MBAC_A_CTRL && pwdata[`MBAC_C_BEXIT]) begin
                boot_q <= 1'b0;
            end
            // Call set beats a same-cycle software write
            if (vectored_os_call && !variant_no_os) begin
                swh_q <= swh_q | (8'h01 << `MBAC_SWH_OS);
            end else if (apb_wr && paddr == `MBAC_A_SWH) begin
                swh_q <= pwdata[7:0];
            end
            os_switch_q <= vectored_os_call && !variant_no_os;
        end
    end
    // Fault record; a new fault beats a same-cycle clear
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flt_q <= 1'b0;
            flt_op_q <= 2'h0;
            flt_sfr_q <= 1'b0;
            flt_addr_q <= 16'h0000;
        end else if ((cpu_req && !mem_ok) || (!cpu_req && sfr_req && !sfr_ok)) begin
            flt_q <= 1'b1;
            flt_op_q <= cpu_req ? cpu_op : {1'b0, sfr_write};
            flt_sfr_q <= !cpu_req;
            flt_addr_q <= cpu_req ? cpu_vaddr : {8'h00, sfr_addr};
        end else if (clr_flt) begin
            flt_q <= 1'b0;
        end
    end
    // Table loader: two words per entry from the pointer onward
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            wcnt_q <= 7'h00;
            tbl_req_q <= 1'b0;
            tbl_addr_q <= 24'h000000;
            perm_q <= 256'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (load_go) begin
                        st_q <= ST_REQ;
                        wcnt_q <= 7'h00;
                        perm_q <= 256'h0;
                    end
                end
                ST_REQ: begin
                    tbl_req_q <= 1'b1;
                    tbl_addr_q <= ptr_q + {15'h0000, wcnt_q, 2'h0};
                    st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (tbl_ack) begin
                        tbl_req_q <= 1'b0;
                        if (wcnt_q[0]) begin
                            perm_q[4*wcnt_q[6:1] +: 4] <= tbl_rdata[`MBAC_E_SFR:`MBAC_E_R];
                        end
                        if (wcnt_q == `MBAC_NWORD) begin
                            st_q <= ST_IDLE;
                        end else begin
                            wcnt_q <= wcnt_q + 7'h01;
                            st_q <= ST_REQ;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // Address fields live in plain storage; permissions gate their use
    always @(posedge clk_sys) begin
        if (st_q == ST_WAIT && tbl_ack) begin
            if (wcnt_q[0]) begin
                seg_off[wcnt_q[6:1]] <= tbl_rdata[15:0];
            end else begin
                seg_first[wcnt_q[6:1]] <= tbl_rdata[31:16];
                seg_last[wcnt_q[6:1]] <= tbl_rdata[15:0];
            end
        end
    end
    // Software registers
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= 24'h000000;
            fw_q <= 16'h0000;
            xbase_q <= 16'h0000;
            xsize_q <= 16'h0000;
        end else if (apb_wr) begin
            case (paddr)
                `MBAC_A_PTR: ptr_q <= pwdata[23:0];
                `MBAC_A_FWL: fw_q[7:0] <= pwdata[7:0];
                `MBAC_A_FWH: fw_q[15:8] <= pwdata[7:0];
                `MBAC_A_XBL: xbase_q[7:0] <= pwdata[7:0];
                `MBAC_A_XBH: xbase_q[15:8] <= pwdata[7:0];
                `MBAC_A_XSL: xsize_q[7:0] <= pwdata[7:0];
                `MBAC_A_XSH: xsize_q[15:8] <= pwdata[7:0];
                default: ptr_q <= ptr_q;
            endcase
        end
    end
    // APB slave: one wait state so every answer leaves a flip-flop
    reg [31:0] rd_d;
    reg err_d;
    always @* begin
        err_d = 1'b0;
        case (paddr)
            `MBAC_A_CTRL: rd_d = {31'h0, loading};
            `MBAC_A_SWH: rd_d = {24'h0, swh_q};
            `MBAC_A_PTR: rd_d = {8'h00, ptr_q};
            `MBAC_A_FWL: rd_d = {24'h0, fw_q[7:0]};
            `MBAC_A_FWH: rd_d = {24'h0, fw_q[15:8]};
            `MBAC_A_XBL: rd_d = {24'h0, xbase_q[7:0]};
            `MBAC_A_XBH: rd_d = {24'h0, xbase_q[15:8]};
            `MBAC_A_XSL: rd_d = {24'h0, xsize_q[7:0]};
            `MBAC_A_XSH: rd_d = {24'h0, xsize_q[15:8]};
            `MBAC_A_MODE: rd_d = {27'h0, loading, variant_no_os, mode_q};
            `MBAC_A_FLT: rd_d = {28'h0, flt_sfr_q, flt_op_q, flt_q};
            `MBAC_A_FADR: rd_d = {16'h0, flt_addr_q};
            default: begin
                rd_d = 32'h0;
                err_d = 1'b1;
            end
        endcase
    end
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= err_d;
            prdata <= pwrite ? 32'h0 : rd_d;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule // mbac_top

//--- verif/mbac_tbl_mem.sv
// Table memory model answering segment table fetches
module mbac_tbl_mem (
    input logic clk_sys,
    input logic rstn,
    input logic tbl_req_q,
    input logic [23:0] tbl_addr_q,
    output logic [31:0] tbl_rdata,
    output logic tbl_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:127];
    logic [1:0] cnt_q;
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 32'h0;
        end
    end
    // Odd words answer slowly to stretch the handshake
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 2'h0;
            tbl_ack <= 1'b0;
            tbl_rdata <= 32'h0;
        end else begin
            tbl_ack <= 1'b0;
            tbl_rdata <= ~tbl_rdata; // Stale data must never look valid
            if (tbl_req_q && !tbl_ack) begin
                if (cnt_q >= {tbl_addr_q[2], tbl_addr_q[2]}) begin
                    tbl_ack <= 1'b1;
                    tbl_rdata <= mem[tbl_addr_q[8:2]];
                    cnt_q <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule // mbac_tbl_mem

//--- verif/mbac_top_assertions.sv
// Port checker for the access control block
`include "mbac_defines.vh"
module mbac_top_chk (
    input wire clk_sys,
    input wire rstn,
    input wire cpu_req,
    input wire [1:0] cpu_op,
    input wire [15:0] cpu_vaddr,
    input wire sfr_req,
    input wire sfr_write,
    input wire [1:0] sfr_class,
    input wire [7:0] sfr_addr,
    input wire variant_no_os,
    input wire vectored_os_call,
    input wire tbl_ack,
    input logic acc_done_q,
    input logic acc_fault_q,
    input logic mem_en_q,
    input logic mem_we_q,
    input logic [23:0] mem_addr_q,
    input logic sfr_en_q,
    input logic sfr_we_q,
    input logic [7:0] sfr_addr_q,
    input logic [2:0] mode_q,
    input logic os_switch_q,
    input logic tbl_req_q,
    input logic [23:0] tbl_addr_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_done; (cpu_req || sfr_req) |=> acc_done_q; endproperty
    a_done: assert property (p_done) else $error("no completion");
    property p_fault; acc_fault_q |-> acc_done_q && !mem_en_q && !sfr_en_q; endproperty
    a_fault: assert property (p_fault) else $error("refused access went out");
    property p_memop;
        mem_en_q |-> $past(cpu_req) && (mem_we_q == ($past(cpu_op) == `MBAC_OP_WR));
    endproperty
    a_memop: assert property (p_memop) else $error("wrong memory operation");
    property p_boot; cpu_req && mode_q == `MBAC_M_BOOT ##1 mode_q == `MBAC_M_BOOT
        |-> mem_en_q && mem_addr_q == {8'h00, $past(cpu_vaddr)}; endproperty
    a_boot: assert property (p_boot) else $error("boot access not identity");
    property p_gen; sfr_req && !cpu_req && sfr_class == `MBAC_SFR_GEN |=> sfr_en_q
        && sfr_we_q == $past(sfr_write) && sfr_addr_q == $past(sfr_addr); endproperty
    a_gen: assert property (p_gen) else $error("general register refused");
    property p_mfr; mem_en_q && variant_no_os |-> mem_addr_q < `MBAC_NVM_MFR_BASE
        || mem_addr_q >= `MBAC_NVM_MFR_BASE + `MBAC_NVM_MFR_SIZE; endproperty
    a_mfr: assert property (p_mfr) else $error("reserved region reached");
    property p_noos; variant_no_os |-> mode_q != `MBAC_M_OS; endproperty
    a_noos: assert property (p_noos) else $error("OS mode in reduced variant");
    property p_call; variant_no_os && vectored_os_call |=> !os_switch_q; endproperty
    a_call: assert property (p_call) else $error("call switched mode");
    property p_tbl; tbl_req_q && !tbl_ack |=> tbl_req_q && $stable(tbl_addr_q); endproperty
    a_tbl: assert property (p_tbl) else $error("table request dropped");
endmodule // mbac_top_chk
bind mbac_top mbac_top_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .cpu_req(cpu_req),
    .cpu_op(cpu_op), .cpu_vaddr(cpu_vaddr), .sfr_req(sfr_req), .sfr_write(sfr_write),
    .sfr_class(sfr_class), .sfr_addr(sfr_addr), .variant_no_os(variant_no_os),
    .vectored_os_call(vectored_os_call), .tbl_ack(tbl_ack), .acc_done_q(acc_done_q),
    .acc_fault_q(acc_fault_q), .mem_en_q(mem_en_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .sfr_en_q(sfr_en_q), .sfr_we_q(sfr_we_q),
    .sfr_addr_q(sfr_addr_q), .mode_q(mode_q), .os_switch_q(os_switch_q),
    .tbl_req_q(tbl_req_q), .tbl_addr_q(tbl_addr_q));

//--- verif/test_mode_based_access_control.sv
// Self-checking bench for the access control block
`include "mbac_defines.vh"
module test_mode_based_access_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00, sfr_addr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic variant_no_os = 0, test_mode_req = 0, vectored_os_call = 0;
    logic cpu_req = 0, sfr_req = 0, sfr_write = 0;
    logic [1:0] cpu_op = 2'h0, sfr_class = 2'h0;
    logic [3:0] sfr_unit = 4'h0;
    logic [15:0] cpu_vaddr = 16'h0;
    wire [31:0] prdata, tbl_rdata;
    wire [23:0] mem_addr_q, tbl_addr_q;
    wire [7:0] sfr_addr_q, mem_wdata_q, sfr_wdata_q;
    wire [2:0] mode_q;
    wire pready, pslverr, acc_done_q, acc_fault_q, mem_en_q, mem_we_q, sfr_en_q, sfr_we_q;
    wire os_switch_q, tbl_req_q, tbl_ack;
    int errors = 0, n_compared = 0;
    mbac_top DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .variant_no_os(variant_no_os), .test_mode_req(test_mode_req),
        .vectored_os_call(vectored_os_call), .cpu_req(cpu_req), .cpu_op(cpu_op),
        .cpu_vaddr(cpu_vaddr), .cpu_wdata(cpu_vaddr[7:0]), .sfr_req(sfr_req),
        .sfr_write(sfr_write), .sfr_class(sfr_class), .sfr_unit(sfr_unit), .sfr_addr(sfr_addr),
        .acc_done_q(acc_done_q), .acc_fault_q(acc_fault_q), .mem_en_q(mem_en_q),
        .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .sfr_en_q(sfr_en_q), .sfr_we_q(sfr_we_q), .sfr_addr_q(sfr_addr_q),
        .sfr_wdata_q(sfr_wdata_q), .mode_q(mode_q),
        .os_switch_q(os_switch_q), .tbl_req_q(tbl_req_q), .tbl_addr_q(tbl_addr_q),
        .tbl_rdata(tbl_rdata), .tbl_ack(tbl_ack));
    mbac_tbl_mem u_mem (.clk_sys(clk_sys), .rstn(rstn), .tbl_req_q(tbl_req_q),
        .tbl_addr_q(tbl_addr_q), .tbl_rdata(tbl_rdata), .tbl_ack(tbl_ack));
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic acc(input logic [1:0] op, input logic [15:0] va, input logic ok,
        input logic [23:0] pa);
        @(posedge clk_sys);
        cpu_op <= op;
        cpu_vaddr <= va;
        cpu_req <= 1'b1;
        @(posedge clk_sys);
        cpu_req <= 1'b0;
        #1;
        chk(acc_done_q, 1);
        chk(acc_fault_q, !ok);
        chk(mem_en_q, ok);
        if (ok) chk(mem_addr_q, pa);
        chk(mem_we_q, ok && op == `MBAC_OP_WR);
        chk(mem_wdata_q, va[7:0]);
    endtask
    task automatic sfr(input logic [1:0] cls, input logic [3:0] u, input logic ok);
        @(posedge clk_sys);
        sfr_class <= cls;
        sfr_unit <= u;
        sfr_write <= 1'b1;
        sfr_addr <= 8'hC4;
        sfr_req <= 1'b1;
        @(posedge clk_sys);
        sfr_req <= 1'b0;
        #1;
        chk(acc_fault_q, !ok);
        chk(sfr_en_q, ok);
        chk(sfr_we_q, ok);
        chk(sfr_addr_q, 8'hC4);
        chk(sfr_wdata_q, cpu_vaddr[7:0]);
    endtask
    task automatic pulse_call();
        @(posedge clk_sys);
        vectored_os_call <= 1'b1;
        @(posedge clk_sys);
        vectored_os_call <= 1'b0;
        #1;
    endtask
    // Reset also carries the variant change, which is static while running
    task automatic bring_up(input logic v);
        int n = 0;
        rstn <= 1'b0;
        variant_no_os <= v;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        apb(0, `MBAC_A_MODE, 0);
        chk(rd, {27'h0, 1'b0, v, 3'h0});
        apb(0, 8'h30, 0);
        chk(err, 1);
        apb(1, `MBAC_A_PTR, 32'h400);
        apb(1, `MBAC_A_CTRL, 32'h1);
        do begin
            apb(0, `MBAC_A_MODE, 0);
            n++;
        end while (rd[4] !== 1'b0 && n < 400);
        chk(rd[4], 0);
        for (int op = 0; op < 3; op++) acc(op, 16'h3000 + op, 1, 24'h003000 + op);
        for (int c = 0; c < 4; c++) sfr(c, 0, 1);
        apb(1, `MBAC_A_SWH, 0);
        apb(1, `MBAC_A_CTRL, 32'h2);
        repeat (2) @(posedge clk_sys);
        #1 chk(mode_q, `MBAC_M_USER);
        $display("bring_up done");
    endtask
    task automatic t_user();
        acc(`MBAC_OP_EX, 16'h1010, 1, 24'h001210);
        acc(`MBAC_OP_RD, 16'h10FF, 1, 24'h0012FF);
        acc(`MBAC_OP_WR, 16'h1010, 0, 0);
        apb(0, `MBAC_A_FLT, 0);
        chk(rd, 32'h3);
        apb(1, `MBAC_A_FLT, 1);
        apb(0, `MBAC_A_FLT, 0);
        chk(rd[0], 0);
        acc(`MBAC_OP_RD, 16'h1100, 0, 0);
        sfr(`MBAC_SFR_HW, 0, 1);
        sfr(`MBAC_SFR_SYS, 0, 0);
        acc(`MBAC_OP_WR, 16'h2010, 1, 24'h002110);
        acc(`MBAC_OP_RD, 16'h2010, 0, 0);
        acc(`MBAC_OP_EX, 16'h2010, 1, 24'h002110);
        sfr(`MBAC_SFR_HW, 0, 0);
        @(posedge clk_sys) test_mode_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk(mode_q, `MBAC_M_TEST);
        @(posedge clk_sys) test_mode_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk(mode_q, `MBAC_M_USER);
        $display("t_user done");
    endtask
    task automatic t_os();
        pulse_call();
        chk(os_switch_q, 1);
        repeat (2) @(posedge clk_sys);
        #1 chk(mode_q, `MBAC_M_OS);
        apb(1, `MBAC_A_FWL, 32'h2);
        sfr(`MBAC_SFR_HW, 1, 1);
        sfr(`MBAC_SFR_HW, 0, 0);
        // Empty exchange window keeps OS mode out of RAM
        acc(`MBAC_OP_RD, 16'h1010, 0, 0);
        apb(1, `MBAC_A_XSH, 32'h13);
        acc(`MBAC_OP_RD, 16'h10FF, 1, 24'h0012FF);
        apb(1, `MBAC_A_SWH, 0);
        apb(1, `MBAC_A_FWL, 32'h1);
        acc(`MBAC_OP_RD, 16'h10FF, 0, 0);
        $display("t_os done");
    endtask
    task automatic t_noos();
        pulse_call();
        chk(os_switch_q, 0);
        repeat (2) @(posedge clk_sys);
        #1 chk(mode_q, `MBAC_M_USER);
        apb(1, `MBAC_A_FWL, 32'h1);
        apb(1, `MBAC_A_XSH, 32'h13);
        acc(`MBAC_OP_EX, 16'h1010, 1, 24'h001210);
        acc(`MBAC_OP_RD, 16'h4010, 0, 0);
        acc(`MBAC_OP_RD, 16'h407F, 0, 0);
        acc(`MBAC_OP_RD, 16'h4080, 1, 24'h020080);
        // OS bit set too: reduced variant must still give system mode
        apb(1, `MBAC_A_SWH, 32'h3);
        sfr(`MBAC_SFR_SYS, 0, 1);
        $display("t_noos done");
    endtask
    initial begin
        // Let the model's own clearing run first
        #1;
        u_mem.mem[0] = 32'h100010FF;
        u_mem.mem[1] = 32'h000D0002;
        u_mem.mem[2] = 32'h200020FF;
        u_mem.mem[3] = 32'h00000005;
        u_mem.mem[4] = 32'h200020FF;
        u_mem.mem[5] = 32'h00060001;
        u_mem.mem[6] = 32'h400040FF;
        u_mem.mem[7] = 32'h000701C0;
        bring_up(0);
        t_user();
        t_os();
        bring_up(1);
        t_noos();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end
endmodule // test_mode_based_access_control
